// File: logic/banked_gpr_consts.svh
// Purpose: constants for the banked register file
// Assumes: 16-bit data, 3-bit register index
// Notes: definitions only
`ifndef BANKED_GPR_CONSTS_SVH
`define BANKED_GPR_CONSTS_SVH
`define WORD_W 16
`define INDEX_W 3
`define BANK_REGS 6
`define SP_INDEX 3'h6
`define PC_INDEX 3'h7
`define MODE_CUR_HI 15
`define MODE_CUR_LO 14
`define MODE_PREV_HI 13
`define MODE_PREV_LO 12
`define BANK_SEL_BIT 11
`define MODE_KERNEL 2'h0
`define MODE_SUPER 2'h1
`define MODE_RSVD 2'h2
`define MODE_USER 2'h3
`define STACK_STEP 16'h0002
`define WORD_RESET 16'h0000
`define STATUS_RESET 16'h0000
`endif

// File: logic/banked_gpr_pkg.sv
// Purpose: shared types for the banked register file
// Assumes: constants come from banked_gpr_consts.svh
// Notes: types only
`include "banked_gpr_consts.svh"
package banked_gpr_pkg;
    typedef logic [`WORD_W-1:0] word_t;
    typedef logic [`INDEX_W-1:0] index_t;
    typedef logic [1:0] mode_t;
    typedef struct packed {
        logic en;
        index_t idx;
        word_t data;
    } write_req_t;
    typedef struct packed {
        logic start;
        word_t newStatus;
        word_t newPc;
    } trap_req_t;
    typedef enum logic [2:0] {
        IDLE = 3'b001,
        PUSH_STATUS = 3'b010,
        PUSH_PC = 3'b100
    } trap_state_t;
endpackage : banked_gpr_pkg

// File: logic/stack_select.sv
// Purpose: picks the stack pointer slot for a mode code
// Assumes: reserved mode code is flagged, kernel slot used
// Notes: purely combinational
`include "banked_gpr_consts.svh"
module stack_select (
    // mode in
    input wire banked_gpr_pkg::mode_t mode,
    // selection out
    output logic [1:0] slot,
    output logic reserved
);
    assign slot = (mode == `MODE_USER) ? 2'h2 : (mode == `MODE_SUPER) ? 2'h1 : 2'h0;
    assign reserved = (mode == `MODE_RSVD);
endmodule : stack_select

// File: logic/privilege_check.sv
// Purpose: flags privileged instructions outside kernel mode
// Assumes: datapath marks privileged opcodes
// Notes: combinational
`include "banked_gpr_consts.svh"
module privilege_check (
    // inputs
    input wire banked_gpr_pkg::mode_t mode,
    input wire logic privileged,
    // result
    output logic inhibit
);
    assign inhibit = privileged && (mode != `MODE_KERNEL);
endmodule : privilege_check

// File: logic/banked_gpr_file.sv
// Purpose: banked working registers, per-mode stack pointers, shared program counter
// Assumes: status word is written by the datapath; one write per cycle
// Notes: trap sequence pushes status then pc onto the new mode's stack
// Function
// - two banks of six working registers each, twelve in total
// - three stack pointers, one per kernel, supervisor, user mode
// - one program counter shared by all modes and banks at index seven
// - index six reaches the stack pointer of the current mode
// - only the selected bank is reachable through indices zero to five
// - bank chosen by a status word field only
// - bank field zero selects bank zero, one selects bank one
// - trap switches mode and pushes old status onto new mode's stack
// - program counter holds next address and reads as an operand
// - stack pointer points at the most recently pushed entry
// - privileged instructions inhibited outside kernel mode
// - current mode in status bits 15:14, previous in 13:12
`include "banked_gpr_consts.svh"
module banked_gpr_file (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // read ports
    input wire banked_gpr_pkg::index_t readIdxA,
    input wire banked_gpr_pkg::index_t readIdxB,
    output banked_gpr_pkg::word_t readDataA,
    output banked_gpr_pkg::word_t readDataB,
    // write port
    input wire banked_gpr_pkg::write_req_t writeReq,
    // status word load
    input wire logic statusLoad,
    input wire banked_gpr_pkg::word_t statusIn,
    // next instruction address
    input wire logic pcLoad,
    input wire banked_gpr_pkg::word_t pcIn,
    // trap entry
    input wire banked_gpr_pkg::trap_req_t trapReq,
    // privilege query
    input wire logic privilegedOp,
    // outputs
    output banked_gpr_pkg::word_t processorStatusWord,
    output banked_gpr_pkg::word_t programCounter,
    output logic inhibitOp,
    output logic modeReserved,
    output logic trapBusy,
    output logic pushValid,
    output banked_gpr_pkg::word_t pushAddr,
    output banked_gpr_pkg::word_t pushData
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    banked_gpr_pkg::word_t bankReg [2][`BANK_REGS];
    banked_gpr_pkg::word_t stackPtr [3];
    banked_gpr_pkg::word_t pcReg;
    banked_gpr_pkg::word_t status;
    banked_gpr_pkg::word_t savedStatus;
    banked_gpr_pkg::word_t savedPc;
    banked_gpr_pkg::trap_state_t state;
    banked_gpr_pkg::trap_state_t next_state;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire banked_gpr_pkg::mode_t curMode;
    wire bankSel;
    wire [1:0] curSlot;
    wire curRsvd;
    wire inhibitNow;
    wire banked_gpr_pkg::word_t curSp;
    wire banked_gpr_pkg::word_t trapStatus;

    assign curMode = status[`MODE_CUR_HI:`MODE_CUR_LO];
    assign bankSel = status[`BANK_SEL_BIT];
    assign curSp = stackPtr[curSlot];
    assign trapStatus = {trapReq.newStatus[`MODE_CUR_HI:`MODE_CUR_LO], curMode,
        trapReq.newStatus[`MODE_PREV_LO-1:0]};

    // ------------------------------------------------------------
    // mode decoders
    // ------------------------------------------------------------
    stack_select i_stack_select (
        .mode(curMode),
        .slot(curSlot),
        .reserved(curRsvd)
    );

    privilege_check i_privilege_check (
        .mode(curMode),
        .privileged(privilegedOp),
        .inhibit(inhibitNow)
    );

    // ------------------------------------------------------------
    // read ports
    // ------------------------------------------------------------
    function automatic banked_gpr_pkg::word_t readReg(input banked_gpr_pkg::index_t idx);
        if (idx == `PC_INDEX) begin
            readReg = pcReg;
        end else if (idx == `SP_INDEX) begin
            readReg = curSp;
        end else begin
            readReg = bankReg[bankSel][idx];
        end
    endfunction : readReg

    always_comb begin
        readDataA = readReg(readIdxA);
        readDataB = readReg(readIdxB);
    end

    // ------------------------------------------------------------
    // write and push decode
    // ------------------------------------------------------------
    wire idle;
    wire trapStart;
    wire wrBank;
    wire wrSp;
    wire wrPc;
    wire pushing;
    wire banked_gpr_pkg::word_t spDec;
    wire banked_gpr_pkg::word_t pushWord;

    assign idle = (state == banked_gpr_pkg::IDLE);
    assign trapStart = idle && trapReq.start;
    assign wrBank = idle && writeReq.en && (writeReq.idx < `SP_INDEX);
    assign wrSp = idle && writeReq.en && (writeReq.idx == `SP_INDEX);
    assign wrPc = idle && writeReq.en && (writeReq.idx == `PC_INDEX);
    assign pushing = !idle;
    assign spDec = curSp - `STACK_STEP;
    assign pushWord = (state == banked_gpr_pkg::PUSH_STATUS) ? savedStatus : savedPc;

    // ------------------------------------------------------------
    // trap sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            banked_gpr_pkg::IDLE: begin
                if (trapReq.start) begin
                    next_state = banked_gpr_pkg::PUSH_STATUS;
                end
            end
            banked_gpr_pkg::PUSH_STATUS: begin
                next_state = banked_gpr_pkg::PUSH_PC;
            end
            banked_gpr_pkg::PUSH_PC: begin
                next_state = banked_gpr_pkg::IDLE;
            end
            default: begin
                next_state = banked_gpr_pkg::IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= banked_gpr_pkg::IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            status <= `STATUS_RESET;
        end else if (trapStart) begin
            status <= trapStatus;
        end else if (idle && statusLoad) begin
            status <= statusIn;
        end
    end

    // ------------------------------------------------------------
    // saved context
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            savedStatus <= `WORD_RESET;
            savedPc <= `WORD_RESET;
        end else if (trapStart) begin
            savedStatus <= status;
            savedPc <= pcReg;
        end
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pcReg <= `WORD_RESET;
        end else if (trapStart) begin
            pcReg <= trapReq.newPc;
        end else if (wrPc) begin
            pcReg <= writeReq.data;
        end else if (idle && pcLoad) begin
            pcReg <= pcIn;
        end
    end

    // ------------------------------------------------------------
    // working banks
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int b = 0; b < 2; b++) begin
                for (int r = 0; r < `BANK_REGS; r++) begin
                    bankReg[b][r] <= `WORD_RESET;
                end
            end
        end else if (wrBank) begin
            bankReg[bankSel][writeReq.idx] <= writeReq.data;
        end
    end

    // ------------------------------------------------------------
    // stack pointers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int s = 0; s < 3; s++) begin
                stackPtr[s] <= `WORD_RESET;
            end
        end else if (pushing) begin
            stackPtr[curSlot] <= spDec;
        end else if (wrSp) begin
            stackPtr[curSlot] <= writeReq.data;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pushValid <= 1'b0;
        end else begin
            pushValid <= pushing;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pushAddr <= `WORD_RESET;
        end else begin
            pushAddr <= spDec;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pushData <= `WORD_RESET;
        end else begin
            pushData <= pushWord;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            processorStatusWord <= `STATUS_RESET;
        end else begin
            processorStatusWord <= status;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            programCounter <= `WORD_RESET;
        end else begin
            programCounter <= pcReg;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            inhibitOp <= 1'b0;
        end else begin
            inhibitOp <= inhibitNow;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            modeReserved <= 1'b0;
        end else begin
            modeReserved <= curRsvd;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            trapBusy <= 1'b0;
        end else begin
            trapBusy <= trapStart || (state == banked_gpr_pkg::PUSH_STATUS);
        end
    end
endmodule : banked_gpr_file

// File: test/cpu_stack_model.sv
// Purpose: datapath side stack memory that absorbs pushed words
// Assumes: one word per clock cycle with pushValid high
// Notes: read back by the bench
module cpu_stack_model (
    // clock
    input wire logic clock,
    // push port
    input wire logic pushValid,
    input wire banked_gpr_pkg::word_t pushAddr,
    input wire banked_gpr_pkg::word_t pushData
);
    timeunit 1ns;
    timeprecision 1ps;
    banked_gpr_pkg::word_t mem [0:65535];
    always @(posedge clock) if (pushValid) mem[pushAddr] <= pushData;
endmodule : cpu_stack_model

// File: test/banked_gpr_file_sva.sv
// Purpose: port checks of the register file
// Assumes: trap starts spaced by the bench
// Notes: bound to the top module
module banked_gpr_file_sva (
    input logic clock,
    input logic rstn,
    input banked_gpr_pkg::word_t readDataA,
    input banked_gpr_pkg::word_t readDataB,
    input banked_gpr_pkg::index_t readIdxA,
    input banked_gpr_pkg::index_t readIdxB,
    input banked_gpr_pkg::write_req_t writeReq,
    input logic pcLoad,
    input banked_gpr_pkg::word_t pcIn,
    input banked_gpr_pkg::trap_req_t trapReq,
    input logic privilegedOp,
    input banked_gpr_pkg::word_t processorStatusWord,
    input banked_gpr_pkg::word_t programCounter,
    input logic inhibitOp,
    input logic modeReserved,
    input logic trapBusy,
    input logic pushValid,
    input banked_gpr_pkg::word_t pushAddr,
    input banked_gpr_pkg::word_t pushData
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    wire trapGo = trapReq.start && !trapBusy && !pushValid;
    wire pcWr = writeReq.en && (writeReq.idx == 3'h7);
    wire pcGo = pcLoad && !pcWr && !trapReq.start && !trapBusy && !pushValid;
    wire [1:0] mode = processorStatusWord[15:14];
    property p_seq;
        trapGo |-> ##1 (trapBusy && !pushValid) ##1 (pushValid && trapBusy)
            ##1 (pushValid && !trapBusy) ##1 !pushValid;
    endproperty
    a_seq: assert property (p_seq) else $error("push sequence wrong");
    property p_pdata; trapGo |-> ##2 pushData == $past(processorStatusWord, 1); endproperty
    a_pdata: assert property (p_pdata) else $error("pushed status wrong");
    property p_step; pushValid && $past(pushValid) |-> pushAddr == $past(pushAddr) - 16'h0002;
    endproperty
    a_step: assert property (p_step) else $error("push address step wrong");
    property p_nsw;
        trapGo |-> ##2 processorStatusWord == {$past(trapReq.newStatus[15:14], 2),
            $past(mode, 1), $past(trapReq.newStatus[11:0], 2)};
    endproperty
    a_nsw: assert property (p_nsw) else $error("trap status wrong");
    property p_npc; trapGo |-> ##2 programCounter == $past(trapReq.newPc, 2); endproperty
    a_npc: assert property (p_npc) else $error("trap pc wrong");
    property p_pc; pcGo |-> ##2 programCounter == $past(pcIn, 2); endproperty
    a_pc: assert property (p_pc) else $error("pc load wrong");
    property p_rsv; modeReserved == (mode == 2'h2); endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
    property p_inh; inhibitOp == ($past(privilegedOp) && mode != 2'h0); endproperty
    a_inh: assert property (p_inh) else $error("inhibit wrong");
    property p_rd;
        (readIdxA == 3'h7 && readIdxB == 3'h7) |=>
            (programCounter == $past(readDataA) && programCounter == $past(readDataB));
    endproperty
    a_rd: assert property (p_rd) else $error("pc read port wrong");
    c_trap: cover property (trapGo);
    c_rsv: cover property (modeReserved);
    c_inh: cover property (inhibitOp);
endmodule : banked_gpr_file_sva
bind banked_gpr_file banked_gpr_file_sva i_banked_gpr_file_sva (.clock, .rstn, .readDataA,
    .readDataB, .readIdxA, .readIdxB, .writeReq, .pcLoad, .pcIn, .trapReq, .privilegedOp,
    .processorStatusWord, .programCounter, .inhibitOp, .modeReserved, .trapBusy,
    .pushValid, .pushAddr, .pushData);

// File: test/banked_gpr_file_tb.sv
// Purpose: directed bench of the register file
// Assumes: inputs change at the falling edge
// Notes: tasks start and end at a falling edge
module banked_gpr_file_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rstn, statusLoad, pcLoad, privilegedOp;
    logic inhibitOp, modeReserved, trapBusy, pushValid;
    banked_gpr_pkg::index_t readIdxA, readIdxB;
    banked_gpr_pkg::word_t readDataA, readDataB, statusIn, pcIn, processor_status_word, pc, pushAddr, pushData;
    banked_gpr_pkg::write_req_t writeReq;
    banked_gpr_pkg::trap_req_t trapReq;
    int failures, num_checks;
    banked_gpr_file i_banked_gpr_file (.clock, .rstn, .readIdxA, .readIdxB, .readDataA,
        .readDataB, .writeReq, .statusLoad, .statusIn, .pcLoad, .pcIn, .trapReq,
        .privilegedOp, .processorStatusWord(processor_status_word), .programCounter(pc), .inhibitOp,
        .modeReserved, .trapBusy, .pushValid, .pushAddr, .pushData);
    cpu_stack_model i_cpu_stack_model (.clock, .pushValid, .pushAddr, .pushData);
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task chk(input banked_gpr_pkg::word_t got, input banked_gpr_pkg::word_t exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task cyc(); @(negedge clock); endtask : cyc
    task wr(input banked_gpr_pkg::index_t i, input banked_gpr_pkg::word_t d);
        writeReq = '{1'b1, i, d};
        cyc();
        writeReq.en = 1'b0;
        cyc();
    endtask : wr
    task st(input banked_gpr_pkg::word_t s);
        statusIn = s;
        statusLoad = 1'b1;
        cyc();
        statusLoad = 1'b0;
        cyc();
    endtask : st
    task rd(input banked_gpr_pkg::index_t i, input banked_gpr_pkg::word_t e);
        readIdxA = i;
        readIdxB = i;
        #1 chk(readDataA, e);
        chk(readDataB, e);
        cyc();
    endtask : rd
    task t_banks();
        for (int i = 0; i < 6; i++) wr(3'(i), 16'h1000 + 16'(i));
        st(16'h0800);
        for (int i = 0; i < 6; i++) wr(3'(i), 16'h2000 + 16'(i));
        for (int i = 0; i < 6; i++) rd(3'(i), 16'h2000 + 16'(i));
        st(16'h0000);
        for (int i = 0; i < 6; i++) rd(3'(i), 16'h1000 + 16'(i));
        $display("banks done");
    endtask : t_banks
    task t_modes();
        for (int m = 0; m < 4; m++) if (m != 2) begin
            st({2'(m), 14'h0000});
            wr(3'h6, 16'h4000 + 16'(m * 256));
        end
        for (int m = 0; m < 4; m++) if (m != 2) begin
            st({2'(m), 14'h0000});
            rd(3'h6, 16'h4000 + 16'(m * 256));
        end
        st(16'h8000);
        cyc();
        chk(16'(modeReserved), 16'h0001);
        rd(3'h6, 16'h4000);
        $display("modes done");
    endtask : t_modes
    task t_pc();
        pcIn = 16'h0abc;
        pcLoad = 1'b1;
        cyc();
        pcLoad = 1'b0;
        rd(3'h7, 16'h0abc);
        pcIn = 16'h1111;
        pcLoad = 1'b1;
        writeReq = '{1'b1, 3'h7, 16'h2222};
        cyc();
        pcLoad = 1'b0;
        writeReq.en = 1'b0;
        st(16'h0800);
        rd(3'h7, 16'h2222);
        chk(pc, 16'h2222);
        $display("pc done");
    endtask : t_pc
    task t_trap();
        st(16'hc000);
        trapReq = '{1'b1, 16'h0000, 16'h0100};
        cyc();
        trapReq.start = 1'b0;
        repeat (4) cyc();
        chk(i_cpu_stack_model.mem[16'h3ffe], 16'hc000);
        chk(i_cpu_stack_model.mem[16'h3ffc], 16'h2222);
        rd(3'h6, 16'h3ffc);
        rd(3'h7, 16'h0100);
        chk(processor_status_word, 16'h3000);
        $display("trap done");
    endtask : t_trap
    task t_priv();
        st(16'h4000);
        privilegedOp = 1'b1;
        cyc();
        chk(16'(inhibitOp), 16'h0001);
        st(16'h0000);
        cyc();
        chk(16'(inhibitOp), 16'h0000);
        privilegedOp = 1'b0;
        $display("privilege done");
    endtask : t_priv
    initial begin
        {rstn, statusLoad, pcLoad, privilegedOp, readIdxA, readIdxB} = '0;
        {statusIn, pcIn, writeReq, trapReq} = '0;
        failures = 0;
        num_checks = 0;
        repeat (20) cyc();
        rstn = 1'b1;
        rd(3'h7, 16'h0000);
        t_banks();
        t_modes();
        t_pc();
        t_trap();
        t_priv();
        end_sim();
    end
    initial begin
        #20us failures++;
        end_sim();
    end
endmodule : banked_gpr_file_tb
